// *** hdl/i2crs_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2crs_slave (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [i2crs_pkg::STRAP_W-1:0] address_strap_pins,
    input wire logic io_update_pin,
    output logic [i2crs_pkg::RADDR_W-1:0] reg_addr_o,
    output logic [i2crs_pkg::DATA_W-1:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [i2crs_pkg::DATA_W-1:0] reg_rdata_i,
    input wire logic reg_denied_i,
    output logic io_update_o
);
    import i2crs_pkg::*;

    // ------------------------------------------------
    // link side: line sampling and glitch filter
    // ------------------------------------------------
    logic [1:0] pin_in;
    logic [1:0] line_f;
    assign pin_in = {sda_i, scl_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ln
            logic s1_q;
            logic s2_q;
            logic [FILT_N-1:0] hist_q;
            logic f_q;
            wire all_hi = &hist_q;
            wire all_lo = ~|hist_q;
            always_ff @(posedge link_clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_q <= 1'b1;
                    s2_q <= 1'b1;
                    hist_q <= '1;
                    f_q <= 1'b1;
                end else begin
                    s1_q <= pin_in[gi];
                    s2_q <= s1_q;
                    hist_q <= {hist_q[FILT_N-2:0], s2_q};
                    // level must hold for the whole window
                    if (all_hi) begin
                        f_q <= 1'b1;
                    end else if (all_lo) begin
                        f_q <= 1'b0;
                    end
                end
            end
            assign line_f[gi] = f_q;
        end
    endgenerate

    wire scl_f = line_f[0];
    wire sda_f = line_f[1];
    logic scl_p_q;
    logic sda_p_q;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    wire scl_rise = scl_f & ~scl_p_q;
    wire scl_fall = ~scl_f & scl_p_q;
    wire scl_hh = scl_f & scl_p_q;
    wire start_ev = scl_hh & sda_p_q & ~sda_f;
    wire stop_ev = scl_hh & ~sda_p_q & sda_f;
    wire ev_ok = ~start_ev & ~stop_ev;

    // ------------------------------------------------
    // link side: strap capture after reset
    // ------------------------------------------------
    logic [STRAP_W-1:0] strap_s1_q;
    logic [STRAP_W-1:0] strap_s2_q;
    logic [STRAP_W-1:0] strap_q;
    logic [1:0] strap_cnt_q;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_s1_q <= '0;
            strap_s2_q <= '0;
            strap_q <= '0;
            strap_cnt_q <= 2'h0;
        end else begin
            strap_s1_q <= address_strap_pins;
            strap_s2_q <= strap_s1_q;
            if (strap_cnt_q != 2'h3) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end
            if (strap_cnt_q == STRAP_WAIT) begin
                strap_q <= strap_s2_q;
            end
        end
    end

    // ------------------------------------------------
    // link side: frame engine
    // ------------------------------------------------
    i2crs_state_t st_q;
    logic [3:0] bit_cnt_q;
    logic [1:0] byte_idx_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] rbuf_q;
    logic rw_q;
    logic oe_q;
    logic mack_q;
    logic [RADDR_W-1:0] addr_q;
    logic req_tgl_q;
    logic req_wr_q;
    logic [RADDR_W-1:0] req_addr_q;
    logic [DATA_W-1:0] req_data_q;

    wire addr_hit = shift_q[7:1] == {DEV_ADDR_HI, strap_q};
    wire byte_done = (st_q == ST_RX) && (bit_cnt_q == BITS_BYTE) && scl_fall;
    wire done_ok = byte_done & ev_ok;
    wire is_slave = byte_idx_q == BI_SLAVE;
    wire ld_hi = done_ok & (byte_idx_q == BI_HI);
    wire ld_lo = done_ok & (byte_idx_q == BI_LO);
    wire wr_issue = done_ok & (byte_idx_q == BI_DATA);
    wire rd_first = done_ok & is_slave & addr_hit & shift_q[0];
    wire rd_next = ev_ok & (st_q == ST_MACK) & scl_rise & ~sda_f;
    wire rd_issue = rd_first | rd_next;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= BI_SLAVE;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            mack_q <= 1'b0;
        end else if (start_ev) begin
            // repeated start also lands here
            st_q <= ST_RX;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= BI_SLAVE;
            oe_q <= 1'b0;
        end else if (stop_ev) begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    oe_q <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_f};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_q <= 4'h0;
                        if (is_slave && !addr_hit) begin
                            st_q <= ST_IDLE;
                        end else begin
                            st_q <= ST_ACK;
                            oe_q <= 1'b1;
                        end
                        if (is_slave) begin
                            rw_q <= shift_q[0];
                        end
                        if (byte_idx_q != BI_DATA) begin
                            byte_idx_q <= byte_idx_q + 2'h1;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (rw_q) begin
                            st_q <= ST_TX;
                            tx_q <= rbuf_q;
                            oe_q <= ~rbuf_q[7];
                        end else begin
                            st_q <= ST_RX;
                            oe_q <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == BIT_LAST) begin
                            st_q <= ST_MACK;
                            oe_q <= 1'b0;
                            mack_q <= 1'b0;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            oe_q <= ~tx_q[6];
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (sda_f) begin
                            st_q <= ST_IDLE;
                        end else begin
                            mack_q <= 1'b1;
                        end
                    end else if (scl_fall && mack_q) begin
                        st_q <= ST_TX;
                        tx_q <= rbuf_q;
                        oe_q <= ~rbuf_q[7];
                        bit_cnt_q <= 4'h0;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------
    // link side: pointer and request words
    // ------------------------------------------------
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_q <= '0;
            req_tgl_q <= 1'b0;
            req_wr_q <= 1'b0;
            req_addr_q <= '0;
            req_data_q <= '0;
        end else begin
            if (ld_hi) begin
                addr_q[15:8] <= shift_q;
            end
            if (ld_lo) begin
                addr_q[7:0] <= shift_q;
            end
            if (wr_issue || rd_issue) begin
                // words stay put until the next toggle
                req_tgl_q <= ~req_tgl_q;
                req_wr_q <= wr_issue;
                req_addr_q <= addr_q;
                req_data_q <= shift_q;
                addr_q <= addr_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------
    // link side: read data return
    // ------------------------------------------------
    logic ack_tgl_q;
    logic [DATA_W-1:0] rdata_q;
    logic [2:0] ack_sy_q;
    wire ack_ev = ack_sy_q[2] ^ ack_sy_q[1];

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_sy_q <= 3'h0;
            rbuf_q <= 8'h00;
        end else begin
            ack_sy_q <= {ack_sy_q[1:0], ack_tgl_q};
            if (ack_ev) begin
                rbuf_q <= rdata_q;
            end
        end
    end

    // open drain: only ever pulls low; no clock output exists
    assign sda_oe = oe_q;

    // ------------------------------------------------
    // system side: request intake
    // ------------------------------------------------
    logic [2:0] req_sy_q;
    logic [2:0] upd_sy_q;
    logic chk_q;
    logic wr_q;
    logic upd_q;
    logic low_q;
    logic [RD_WAIT-1:0] rd_pipe_q;
    logic [RADDR_W-1:0] raddr_q;
    logic [DATA_W-1:0] wdata_q;

    wire req_ev = req_sy_q[2] ^ req_sy_q[1];
    wire upd_pin_ev = upd_sy_q[1] & ~upd_sy_q[2];
    wire wr_ok = chk_q & ~reg_denied_i;
    wire upd_hit = (raddr_q == UPDATE_ADDR) & wdata_q[UPDATE_BIT];
    wire rd_take = rd_pipe_q[RD_WAIT-1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_sy_q <= 3'h0;
            upd_sy_q <= 3'h0;
            raddr_q <= '0;
            wdata_q <= '0;
            chk_q <= 1'b0;
            rd_pipe_q <= '0;
        end else begin
            req_sy_q <= {req_sy_q[1:0], req_tgl_q};
            upd_sy_q <= {upd_sy_q[1:0], io_update_pin};
            if (req_ev) begin
                raddr_q <= req_addr_q;
                wdata_q <= req_data_q;
            end
            chk_q <= req_ev & req_wr_q;
            rd_pipe_q <= {rd_pipe_q[RD_WAIT-2:0], req_ev & ~req_wr_q};
        end
    end

    // ------------------------------------------------
    // system side: strobes and read answer
    // ------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= 1'b0;
            upd_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            rdata_q <= 8'h00;
            low_q <= 1'b0;
        end else begin
            wr_q <= wr_ok;
            upd_q <= (wr_ok & upd_hit) | upd_pin_ev;
            low_q <= 1'b0;
            if (rd_take) begin
                rdata_q <= reg_denied_i ? 8'h00 : reg_rdata_i;
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end

    assign reg_addr_o = raddr_q;
    assign reg_wdata_o = wdata_q;
    assign reg_wr_o = wr_q;
    assign reg_rd_o = rd_pipe_q[0];
    assign io_update_o = upd_q;
    assign sda_o = low_q;

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    sequence s_nack;
        st_q == ST_MACK && scl_rise && sda_f && ev_ok;
    endsequence

    sequence s_hit_done;
        byte_done && ev_ok && is_slave && addr_hit;
    endsequence

    sequence s_wr_check;
        chk_q && reg_denied_i;
    endsequence

    AST_IDLE_RELEASED: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        (st_q == ST_IDLE) |-> !sda_oe)
        else $error("data line driven while idle");

    AST_START_RESTARTS: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        start_ev |=> (st_q == ST_RX) && (bit_cnt_q == 4'h0) && (byte_idx_q == BI_SLAVE))
        else $error("start did not restart the frame");

    AST_STOP_IDLES: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        stop_ev |=> (st_q == ST_IDLE) && !sda_oe)
        else $error("stop did not return to idle");

    AST_ACK_HELD: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        s_hit_done |=> sda_oe && (st_q == ST_ACK))
        else $error("matching address not acknowledged");

    AST_MACK_RELEASED: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        (st_q == ST_MACK) |-> !sda_oe)
        else $error("data line driven in master ack slot");

    AST_NACK_ENDS: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        s_nack |=> (st_q == ST_IDLE) ##1 !sda_oe)
        else $error("master nack did not end the read");

    AST_OE_CLOCK_LOW: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        (sda_oe != $past(sda_oe)) |-> (!scl_p_q || $past(start_ev || stop_ev)))
        else $error("data line changed while clock high");

    AST_PTR_ADVANCE: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        (wr_issue || rd_issue) |=> addr_q == $past(addr_q) + 16'h0001)
        else $error("register pointer did not advance");

    AST_DENIED_NO_WRITE: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_wr_check |=> !reg_wr_o)
        else $error("write to denied register passed");

    AST_REQ_TO_STROBE: assert property (
        @(posedge clk) disable iff (!arst_n)
        (req_ev && req_wr_q && !reg_denied_i) |=> ##1 (reg_wr_o || reg_denied_i))
        else $error("write request lost");

endmodule // i2crs_slave
`default_nettype wire

// *** common/i2crs_pkg.sv ***
`default_nettype none
package i2crs_pkg;
    // ------------------------------------------------
    // bus address
    // ------------------------------------------------
    localparam int STRAP_W = 3;
    localparam logic [3:0] DEV_ADDR_HI = 4'h9;
    // ------------------------------------------------
    // register interface
    // ------------------------------------------------
    localparam int RADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] UPDATE_ADDR = 16'h0005;
    localparam int UPDATE_BIT = 0;
    localparam int RD_WAIT = 2;
    // ------------------------------------------------
    // link timing
    // ------------------------------------------------
    localparam int GLITCH_NS = 50;
    localparam int LINK_PERIOD_NS = 80;
    localparam int FILT_N = (GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    // ------------------------------------------------
    // frame bookkeeping
    // ------------------------------------------------
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [1:0] BI_SLAVE = 2'h0;
    localparam logic [1:0] BI_HI = 2'h1;
    localparam logic [1:0] BI_LO = 2'h2;
    localparam logic [1:0] BI_DATA = 2'h3;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } i2crs_state_t;
endpackage
`default_nettype wire

// *** tb/i2crs_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2crs_master #(
    parameter int HALF_NS = 1250
) (
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    logic glitch;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        glitch = 1'b0;
    end

    // ------------------------------------------------
    // conditions
    // ------------------------------------------------
    task automatic start();
        if (!scl) begin
            sda_pull = 1'b0;
            #(HALF_NS / 2);
            scl = 1'b1;
        end
        #(HALF_NS);
        sda_pull = 1'b1;
        #(HALF_NS);
        scl = 1'b0;
        #(HALF_NS / 2);
    endtask

    task automatic stop();
        #200;
        sda_pull = 1'b1;
        #(HALF_NS - 200);
        scl = 1'b1;
        #(HALF_NS);
        sda_pull = 1'b0;
        #(HALF_NS);
    endtask

    // ------------------------------------------------
    // bits and bytes
    // ------------------------------------------------
    // optional 30 ns spike on the clock line inside the low phase
    task automatic bit_slot(input logic b, output logic seen);
        #200;
        sda_pull = ~b;
        if (glitch) begin
            #(HALF_NS / 2 - 200);
            scl = 1'b1;
            #30;
            scl = 1'b0;
            #(HALF_NS / 2 - 30);
        end else begin
            #(HALF_NS - 200);
        end
        scl = 1'b1;
        #(HALF_NS);
        seen = sda_line;
        scl = 1'b0;
    endtask

    task automatic wbyte(input logic [7:0] b, input int n, output logic ack);
        logic s;
        ack = 1'b1;
        for (int i = 7; i > 7 - n; i--) begin
            bit_slot(b[i], s);
        end
        if (n == 8) begin
            bit_slot(1'b1, ack);
        end
    endtask

    task automatic rbyte(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, b[i]);
        end
        bit_slot(nack, s);
    endtask
endmodule // i2crs_master
`default_nettype wire

// *** tb/tb_i2c_register_slave_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_register_slave_port;
    import i2crs_pkg::*;
    localparam int LIMIT = 90000;
    logic clk;
    logic arst_n;
    logic link_clk;
    logic scl;
    logic sda_pull;
    logic sda_line;
    logic sda_o;
    logic sda_oe;
    logic io_update_pin;
    logic reg_wr_o;
    logic reg_rd_o;
    logic reg_denied_i;
    logic io_update_o;
    logic [STRAP_W-1:0] strap;
    logic [RADDR_W-1:0] reg_addr_o;
    logic [DATA_W-1:0] reg_wdata_o;
    logic [DATA_W-1:0] reg_rdata_i;
    logic [23:0] exp_q[$];
    int error_cnt;
    int checks;
    int cyc;
    int upd_cnt;
    int rd_cnt;
    int exp_upd;

    // ------------------------------------------------
    // clocks, wire and register model
    // ------------------------------------------------
    initial clk = 1'b0;
    always #2 clk = ~clk;
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end

    // open drain with pull-up
    assign sda_line = ~sda_pull & ~(sda_oe & ~sda_o);
    assign reg_rdata_i = reg_addr_o[7:0] ^ 8'hA5;
    assign reg_denied_i = (reg_addr_o == 16'h0006);

    i2crs_master m (
        .scl(scl),
        .sda_pull(sda_pull),
        .sda_line(sda_line)
    );

    i2crs_slave uut (
        .clk(clk),
        .arst_n(arst_n),
        .link_clk(link_clk),
        .scl_i(scl),
        .sda_i(sda_line),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .address_strap_pins(strap),
        .io_update_pin(io_update_pin),
        .reg_addr_o(reg_addr_o),
        .reg_wdata_o(reg_wdata_o),
        .reg_wr_o(reg_wr_o),
        .reg_rd_o(reg_rd_o),
        .reg_rdata_i(reg_rdata_i),
        .reg_denied_i(reg_denied_i),
        .io_update_o(io_update_o)
    );

    // ------------------------------------------------
    // checking
    // ------------------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic ack;
        m.wbyte(b, 8, ack);
        check("ack", {23'h0, ack}, {23'h0, exp_ack});
    endtask

    // register side monitor, takes the oldest note per write
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (reg_wr_o === 1'b1) begin
            if (exp_q.size() == 0)
                check("write", {reg_addr_o, reg_wdata_o}, 24'hXXXXXX);
            else
                check("write", {reg_addr_o, reg_wdata_o}, exp_q.pop_front());
        end
        if (io_update_o === 1'b1)
            upd_cnt <= upd_cnt + 1;
        // read strobes walk the pointer upward from the address-only write
        if (reg_rd_o === 1'b1) begin
            check("read addr", {reg_addr_o, 8'h00}, {16'(16'h0005 + rd_cnt), 8'h00});
            rd_cnt <= rd_cnt + 1;
        end
        if (cyc == LIMIT) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] rb;
        logic ack;
        void'($urandom(88));
        strap = STRAP_W'($urandom);
        arst_n = 1'b0;
        io_update_pin = 1'b0;
        repeat (8) @(posedge link_clk);
        @(negedge clk);
        arst_n = 1'b1;
        #2000;
        d0 = 8'($urandom) | 8'h01;
        d1 = 8'($urandom);
        // write to update register, then a denied one, then a torn byte
        m.start();
        send({DEV_ADDR_HI, strap, 1'b0}, 1'b0);
        send(8'h00, 1'b0);
        send(8'h05, 1'b0);
        m.glitch = 1'b1;
        exp_q.push_back({16'h0005, d0});
        exp_upd++;
        send(d0, 1'b0);
        send(d1, 1'b0);
        m.glitch = 1'b0;
        m.wbyte(8'hFF, 4, ack);
        m.stop();
        // foreign address, repeated start, address-only write
        m.start();
        send({DEV_ADDR_HI, ~strap, 1'b0}, 1'b1);
        m.start();
        send({DEV_ADDR_HI, strap, 1'b0}, 1'b0);
        send(8'h00, 1'b0);
        send(8'h05, 1'b0);
        m.stop();
        // read from the pointer left behind
        m.start();
        send({DEV_ADDR_HI, strap, 1'b1}, 1'b0);
        m.rbyte(rb, 1'b0);
        check("read", {16'h0, rb}, {16'h0, 8'h05 ^ 8'hA5});
        m.rbyte(rb, 1'b1);
        check("read", {16'h0, rb}, 24'h000000);
        m.stop();
        check("release", {23'h0, sda_oe}, 24'h000000);
        check("pull level", {23'h0, sda_o}, 24'h000000);
        @(negedge clk);
        io_update_pin = 1'b1;
        exp_upd++;
        repeat (10) @(negedge clk);
        check("update", 24'(upd_cnt), 24'(exp_upd));
        check("pending", 24'(exp_q.size()), 24'h000000);
        check("reads", 24'(rd_cnt), 24'h000002);
        wrap_up();
    end
endmodule // tb_i2c_register_slave_port
`default_nettype wire
